// File: verilog/cmp_skip_regs.svh
`ifndef CMP_SKIP_REGS_SVH
`define CMP_SKIP_REGS_SVH
`define OPC_HI 4'h6
`define OPC_LESS 3'h0
`define OPC_EQUAL 3'h1
`define OPC_GREATER 3'h2
`define OPC_LSB 9
`define ABIT_POS 8
`define ACCESS_SPLIT 8'h80
`define ACCESS_HI_BANK 4'hf
`endif

// File: verilog/cmp_skip_pkg.sv
package cmp_skip_pkg;
    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } phase_e;
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_IDLE1,
        ST_IDLE2
    } slot_e;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_LESS,
        OP_EQUAL,
        OP_GREATER
    } cmp_op_e;
endpackage

// File: verilog/compare_skip_instructions.sv
`timescale 1ns/10ps
`include "cmp_skip_regs.svh"
// Behaviour
// - greater opcode 0110010a, skip when f exceeds accumulator
// - equal compare skips next when values match
// - equal opcode is 0110001a plus address
// - less opcode 0110000a, skip when f below accumulator
// - less decided by unsigned subtraction
// - addressed file register compared with accumulator
// - less skip discards fetched word, idle slot
// - greater skip discards fetched word, idle slot
// - a=0 selects access bank, ignores bank select
// - a=1 forms address using bank select register
// - one word, one cycle, two when skipping
// - skipping two-word instruction takes three cycles
// - two-word skip idles two full cycles
// - status flags never changed
module compare_skip_instructions (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic next_two_word_i,
    input wire logic [7:0] accumulator_reg_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [7:0] file_data_i,
    output logic [1:0] phase_o,
    output logic [11:0] file_addr_o,
    output logic file_rd_o,
    output logic skip_taken_o,
    output logic idle_slot_o,
    output logic busy_o,
    output logic file_wr_o,
    output logic status_wr_o
);
    cmp_skip_pkg::phase_e phase_q, phase_d;
    cmp_skip_pkg::slot_e slot_q, slot_d;
    cmp_skip_pkg::cmp_op_e op_q, op_d;
    cmp_skip_pkg::cmp_op_e op_new;
    logic [11:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic skip_q, skip_d;
    logic idle_q, idle_d;
    logic busy_q, busy_d;
    logic two_q, two_d;
    logic file_wr_q, file_wr_d;
    logic status_wr_q, status_wr_d;
    logic [8:0] diff;
    logic cycle_end;
    logic exec_slot;
    logic fetch_now;

    function automatic cmp_skip_pkg::cmp_op_e decode_op(input logic [15:0] w);
        decode_op = cmp_skip_pkg::OP_NONE;
        if (w[15:12] == `OPC_HI) begin
            case (w[11:`OPC_LSB])
                `OPC_LESS: decode_op = cmp_skip_pkg::OP_LESS;
                `OPC_EQUAL: decode_op = cmp_skip_pkg::OP_EQUAL;
                `OPC_GREATER: decode_op = cmp_skip_pkg::OP_GREATER;
                default: decode_op = cmp_skip_pkg::OP_NONE;
            endcase
        end
    endfunction

    function automatic logic [11:0] form_addr(input logic a, input logic [7:0] f,
                                              input logic [3:0] bank);
        if (a) begin
            form_addr = {bank, f};
        end else if (f < `ACCESS_SPLIT) begin
            form_addr = {4'h0, f};
        end else begin
            form_addr = {`ACCESS_HI_BANK, f};
        end
    endfunction

    function automatic logic skip_test(input cmp_skip_pkg::cmp_op_e op,
                                       input logic [8:0] d);
        case (op)
            cmp_skip_pkg::OP_LESS: skip_test = d[8];
            cmp_skip_pkg::OP_EQUAL: skip_test = d == 9'h000;
            cmp_skip_pkg::OP_GREATER: skip_test = !d[8] && d != 9'h000;
            default: skip_test = 1'b0;
        endcase
    endfunction

    // unsigned: bit 8 is the borrow of f minus accumulator, so 8'h80 is large, not negative
    assign diff = {1'b0, file_data_i} - {1'b0, accumulator_reg_i};

    // a cycle ends in Q4; it fetches unless a skip still owes an idle cycle
    always_comb begin
        cycle_end = phase_q == cmp_skip_pkg::PH_Q4;
        exec_slot = slot_q == cmp_skip_pkg::ST_EXEC;
        fetch_now = cycle_end && !(exec_slot && skip_q) &&
                    !(slot_q == cmp_skip_pkg::ST_IDLE1 && two_q);
        op_new = instr_valid_i ? decode_op(instr_i) : cmp_skip_pkg::OP_NONE;
    end

    // every clock is one phase, four make an instruction cycle
    always_comb begin
        phase_d = cmp_skip_pkg::phase_e'(phase_q + 2'h1);
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= cmp_skip_pkg::PH_Q4;
        end else begin
            phase_q <= phase_d;
        end
    end

    always_comb begin
        slot_d = slot_q;
        idle_d = idle_q;
        busy_d = busy_q;
        two_d = two_q;
        case (slot_q)
            cmp_skip_pkg::ST_EXEC: begin
                if (phase_q == cmp_skip_pkg::PH_Q2) begin
                    // taken with the operands, so the skip length is fixed before Q3
                    two_d = next_two_word_i;
                end
                if (cycle_end && skip_q) begin
                    slot_d = cmp_skip_pkg::ST_IDLE1;
                    idle_d = 1'b1;
                    busy_d = 1'b1;
                end
            end
            cmp_skip_pkg::ST_IDLE1: begin
                if (cycle_end && two_q) begin
                    slot_d = cmp_skip_pkg::ST_IDLE2;
                    idle_d = 1'b1;
                end
            end
            default: begin
                slot_d = slot_q;
            end
        endcase
        if (fetch_now) begin
            slot_d = cmp_skip_pkg::ST_EXEC;
            idle_d = 1'b0;
            busy_d = op_new != cmp_skip_pkg::OP_NONE;
            two_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot_q <= cmp_skip_pkg::ST_EXEC;
            idle_q <= 1'b0;
            busy_q <= 1'b0;
            two_q <= 1'b0;
        end else begin
            slot_q <= slot_d;
            idle_q <= idle_d;
            busy_q <= busy_d;
            two_q <= two_d;
        end
    end

    always_comb begin
        op_d = op_q;
        addr_d = addr_q;
        if (fetch_now) begin
            op_d = op_new;
            addr_d = form_addr(instr_i[`ABIT_POS], instr_i[7:0], bank_select_reg_i);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_q <= cmp_skip_pkg::OP_NONE;
            addr_q <= 12'h000;
        end else begin
            op_q <= op_d;
            addr_q <= addr_d;
        end
    end

    always_comb begin
        rd_d = 1'b0;
        skip_d = skip_q;
        case (phase_q)
            cmp_skip_pkg::PH_Q1: begin
                rd_d = exec_slot && op_q != cmp_skip_pkg::OP_NONE;
            end
            cmp_skip_pkg::PH_Q2: begin
                if (exec_slot) begin
                    skip_d = skip_test(op_q, diff);
                end
            end
            cmp_skip_pkg::PH_Q4: begin
                skip_d = 1'b0;
            end
            default: begin
                // Q3 only holds the decision; there is no write-back in Q4
                skip_d = skip_q;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 1'b0;
            skip_q <= 1'b0;
        end else begin
            rd_q <= rd_d;
            skip_q <= skip_d;
        end
    end

    // held low by flops so the write strobes are as clean as the other outputs
    always_comb begin
        file_wr_d = 1'b0;
        status_wr_d = 1'b0;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            file_wr_q <= 1'b0;
            status_wr_q <= 1'b0;
        end else begin
            file_wr_q <= file_wr_d;
            status_wr_q <= status_wr_d;
        end
    end

    assign phase_o = phase_q;
    assign file_addr_o = addr_q;
    assign file_rd_o = rd_q;
    assign skip_taken_o = skip_q;
    assign idle_slot_o = idle_q;
    assign busy_o = busy_q;
    assign file_wr_o = file_wr_q;
    assign status_wr_o = status_wr_q;
endmodule

// File: bench/compare_skip_instructions_monitor.sv
`timescale 1ns/10ps
module cmp_skip_monitor (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    input wire logic next_two_word_i,
    input wire logic [7:0] accumulator_reg_i,
    input wire logic [3:0] bank_select_reg_i,
    input wire logic [7:0] file_data_i,
    input wire logic [1:0] phase_o,
    input wire logic [11:0] file_addr_o,
    input wire logic file_rd_o,
    input wire logic skip_taken_o,
    input wire logic idle_slot_o,
    input wire logic busy_o,
    input wire logic file_wr_o,
    input wire logic status_wr_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic cmp = instr_i[15:11] == 5'h0c && instr_i[10:9] != 2'h3;
    wire logic free = phase_o == 2'h3 && !idle_slot_o && !skip_taken_o;
    // unsigned on purpose: bit 7 set is a large value, not a negative one
    function automatic logic hit(logic [15:0] i, logic [7:0] f, logic [7:0] w);
        hit = i[10] ? f > w : (i[9] ? f == w : f < w);
    endfunction
    function automatic logic [11:0] ea(logic [15:0] i, logic [3:0] b);
        ea = i[8] ? {b, i[7:0]} : {i[7] ? 4'hf : 4'h0, i[7:0]};
    endfunction
    property p_phase; 1 |=> phase_o == $past(phase_o) + 2'h1; endproperty
    a_phase: assert property (p_phase) else $error("phase order");
    property p_take; free && instr_valid_i && cmp |=> busy_o ##1 file_rd_o; endproperty
    a_take: assert property (p_take) else $error("compare not taken");
    property p_other; free && !(instr_valid_i && cmp) |=> !busy_o; endproperty
    a_other: assert property (p_other) else $error("other opcode taken");
    property p_skip; phase_o == 2'h2 && $past(file_rd_o) |-> skip_taken_o ==
        hit($past(instr_i, 3), $past(file_data_i), $past(accumulator_reg_i)); endproperty
    a_skip: assert property (p_skip) else $error("skip decision");
    property p_addr; file_rd_o |-> phase_o == 2'h1 &&
        file_addr_o == ea($past(instr_i, 2), $past(bank_select_reg_i, 2)); endproperty
    a_addr: assert property (p_addr) else $error("file address");
    property p_idle1; skip_taken_o && phase_o == 2'h3 && !$past(next_two_word_i, 2)
        |=> idle_slot_o [*4] ##1 !idle_slot_o; endproperty
    a_idle1: assert property (p_idle1) else $error("one idle cycle");
    property p_idle2; skip_taken_o && phase_o == 2'h3 && $past(next_two_word_i, 2)
        |=> idle_slot_o [*8] ##1 !idle_slot_o; endproperty
    a_idle2: assert property (p_idle2) else $error("two idle cycles");
    property p_nowr; !file_wr_o && !status_wr_o; endproperty
    a_nowr: assert property (p_nowr) else $error("write seen");
endmodule
bind compare_skip_instructions cmp_skip_monitor cmp_skip_monitor_i (.*);

// File: bench/compare_skip_instructions_test.sv
`timescale 1ns/10ps
`define chk(n, e, s) cmp_count++; if ((s) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", n, e, s); end
module compare_skip_instructions_test;
    typedef struct packed {
        logic [15:0] ins;
        logic [7:0] f;
        logic [7:0] w;
        logic [3:0] b;
        logic t;
        logic [3:0] en;
    } row_s;
    logic clk_i = 0, rst_n_i = 0, instr_valid_i = 0, next_two_word_i = 0;
    logic [15:0] instr_i = 0;
    logic [7:0] accumulator_reg_i = 0, file_data_i = 0;
    logic [3:0] bank_select_reg_i = 0;
    logic [1:0] phase_o;
    logic [11:0] file_addr_o;
    logic file_rd_o, skip_taken_o, idle_slot_o, busy_o, file_wr_o, status_wr_o;
    int bad_count = 0, cmp_count = 0;
    // en is the number of busy phases: 4 exec, 4 more per idle cycle
    row_s rows [10] = '{'{16'h6005, 8'h10, 8'h20, 4'h3, 1'b0, 4'h8},
        '{16'h6105, 8'h20, 8'h10, 4'h3, 1'b0, 4'h4}, '{16'h6085, 8'h7f, 8'h80, 4'h3, 1'b0, 4'h8},
        '{16'h63a0, 8'h33, 8'h33, 4'h5, 1'b0, 4'h8}, '{16'h6210, 8'h33, 8'h34, 4'h5, 1'b0, 4'h4},
        '{16'h6490, 8'hff, 8'hfe, 4'h0, 1'b0, 4'h8}, '{16'h6590, 8'h40, 8'h40, 4'h9, 1'b0, 4'h4},
        '{16'h6410, 8'h80, 8'h01, 4'h0, 1'b1, 4'hc}, '{16'h6410, 8'h10, 8'h20, 4'h0, 1'b1, 4'h4},
        '{16'h6600, 8'h10, 8'h20, 4'h0, 1'b0, 4'h0}};
    compare_skip_instructions compare_skip_instructions_i (.*);
    initial forever #25 clk_i = ~clk_i;
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // operand inputs stay put for the whole instruction, so every sampling phase sees them; instr_valid_i drops after the fetch edge
    task run(input row_s r);
        int n;
        {instr_i, file_data_i, accumulator_reg_i, bank_select_reg_i} = {r.ins, r.f, r.w, r.b};
        next_two_word_i = r.t;
        instr_valid_i = 1;
        for (n = 0; phase_o !== 2'h3; n++) begin
            if (n > 8) begin bad_count++; finish_test(); end
            @(posedge clk_i); #2;
        end
        @(posedge clk_i); #2;
        instr_valid_i = 0;
        for (n = 0; busy_o === 1'b1 && n < 20; n++) begin @(posedge clk_i); #2; end
        `chk("busy phases", r.en, n)
    endtask
    initial begin
        repeat (3) @(posedge clk_i); #2;
        rst_n_i = 1;
        foreach (rows[k]) run(rows[k]);
        {instr_i, file_data_i, accumulator_reg_i, instr_valid_i} = {16'h6005, 8'h00, 8'h01, 1'b1};
        repeat (6) @(posedge clk_i); #2;
        rst_n_i = 0;
        #1 `chk("reset", 6'h30, {phase_o, busy_o, idle_slot_o, skip_taken_o, file_rd_o})
        @(posedge clk_i); #2;
        rst_n_i = 1;
        run(rows[3]);
        finish_test();
    end
endmodule
